// File: pkg/bcd_dec_pkg.sv
// Purpose: constants for the decimal adjust / decrement datapath
// Assumes: 8-bit data, 12-bit data address space, four-phase cycle
// Notes:   phase counter steps q1..q4 on each clock of an instruction and holds q1 while idle
package bcd_dec_pkg;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [3:0]  DIGIT_FIX     = 4'h6;
  localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [1:0]  PH_Q1         = 2'h0;
  localparam logic [1:0]  PH_Q2         = 2'h1;
  localparam logic [1:0]  PH_Q3         = 2'h2;
  localparam logic [1:0]  PH_Q4         = 2'h3;
  typedef enum logic [1:0] {OP_NONE, OP_ADJUST, OP_DECR} op_t;
endpackage

// File: rtl/bcd_dec_core.sv
// Purpose: execution of decimal adjust and decrement-file instructions
// Assumes: decoder presents opcode fields stable over the whole q1..q4 cycle
// Notes:   file memory lives outside; this block addresses it and writes back
// Operation
// RQ1: decimal adjust corrects accumulator low and high nibbles as separate digits.
// RQ2: after bcd addition, decimal adjust leaves a valid packed bcd sum.
// RQ3: digit above nine or flag set adds six; high digit also sets carry.
// RQ4: decrement subtracts one from file register chosen by 8-bit address.
// RQ5: destination 0 writes accumulator, destination 1 writes source register.
// RQ6: access bit 0 addresses the access bank.
// RQ7: access bit 1 takes bank number from the bank select register.
// RQ8: extended set, access 0, address up to 95 uses indexed literal offset.
module bcd_dec_core (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // instruction fields
  input  wire logic        start_in,
  input  wire logic        adjust_sel_in,
  input  wire logic        dest_in,
  input  wire logic        access_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic        ext_set_in,
  input  wire logic [3:0]  bank_select_register_in,
  input  wire logic [11:0] index_base_in,
  // status inputs
  input  wire logic        carry_in,
  input  wire logic        nibble_half_flag_in,
  // file memory port
  input  wire logic [7:0]  file_rdata_in,
  output logic      [11:0] file_addr_out,
  output logic      [7:0]  file_wdata_out,
  output logic             file_we_out,
  // accumulator and flags
  output logic      [7:0]  acc_out,
  output logic             carry_out,
  output logic             busy_out,
  output logic             done_out
);
  ////////////////////////////////////////////////////////////////////////////
  // phase and operation tracking
  logic [1:0]             phase;
  bcd_dec_pkg::op_t       op;
  logic [7:0]             operand;
  logic [7:0]             result;
  logic                   result_carry;
  logic                   carry;
  logic [7:0]             acc;
  logic [11:0]            addr_hold;
  logic                   dest_hold;
  logic                   done;

  // address generation: one function, used for latch and drive
  function automatic logic [11:0] file_address(input logic a, input logic ext,
      input logic [7:0] f, input logic [3:0] bank, input logic [11:0] base);
    logic [11:0] addr;
    addr = {bank, f};
    if (!a && ext && f <= bcd_dec_pkg::INDEX_LIMIT)
      addr = base + {4'h0, f};
    else if (!a)
      addr = {(f < bcd_dec_pkg::ACCESS_SPLIT) ? bcd_dec_pkg::ACCESS_LO_BNK
                                              : bcd_dec_pkg::ACCESS_HI_BNK, f};
    return addr;
  endfunction

  // RQ6: access bank, RQ7: banked, RQ8: indexed offset
  wire [11:0] next_addr = file_address(access_in, ext_set_in, addr_in,
                                       bank_select_register_in, index_base_in);

  wire [7:0] fix_value;
  wire       fix_carry;
  // RQ1: digit correction of accumulator
  decimal_fix u_fix (
    .value_in  (acc),
    .carry_in  (carry),
    .half_in   (nibble_half_flag_in),
    .value_out (fix_value),
    .carry_out (fix_carry)
  );

  // RQ4: subtract one from fetched register
  wire [7:0] dec_value = operand - 8'h01;
  wire       active    = (op != bcd_dec_pkg::OP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // q1 decode, q2 read, q3 process, q4 write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase <= bcd_dec_pkg::PH_Q1;
      op    <= bcd_dec_pkg::OP_NONE;
    end else if (!active) begin
      phase <= bcd_dec_pkg::PH_Q1;
      if (start_in)
        op <= adjust_sel_in ? bcd_dec_pkg::OP_ADJUST : bcd_dec_pkg::OP_DECR;
    end else begin
      phase <= phase + 2'h1;
      if (phase == bcd_dec_pkg::PH_Q4)
        op <= bcd_dec_pkg::OP_NONE;
    end
  end

  // instruction fields held for the cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_hold <= 12'h000;
      dest_hold <= 1'b1;
    end else if (!active && start_in) begin
      addr_hold <= next_addr;
      dest_hold <= dest_in;
    end
  end

  // q2 operand read
  always_ff @(posedge clk_in) begin
    if (rst_in)
      operand <= 8'h00;
    else if (active && phase == bcd_dec_pkg::PH_Q2)
      operand <= (op == bcd_dec_pkg::OP_ADJUST) ? acc : file_rdata_in;
  end

  // q3 process
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result       <= 8'h00;
      result_carry <= 1'b0;
    end else if (active && phase == bcd_dec_pkg::PH_Q3) begin
      // RQ2: bcd result from adjust
      result       <= (op == bcd_dec_pkg::OP_ADJUST) ? fix_value : dec_value;
      result_carry <= (op == bcd_dec_pkg::OP_ADJUST) ? fix_carry : carry;
    end
  end

  wire write_phase = active && phase == bcd_dec_pkg::PH_Q4;
  // RQ5: decrement to accumulator when destination clear
  wire acc_write   = write_phase &&
                     (op == bcd_dec_pkg::OP_ADJUST || !dest_hold);

  // q4 write-back of accumulator and carry; carry mirrors the status input while idle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc   <= bcd_dec_pkg::ACC_RESET;
      carry <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= write_phase;
      if (acc_write)
        acc <= result;
      if (write_phase && op == bcd_dec_pkg::OP_ADJUST)
        carry <= result_carry;
      else if (!active)
        carry <= carry_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign file_addr_out  = addr_hold;
  assign file_wdata_out = result;
  // RQ5: write back to file when destination set
  assign file_we_out    = write_phase && op == bcd_dec_pkg::OP_DECR && dest_hold;
  assign acc_out        = acc;
  assign carry_out      = carry;
  assign busy_out       = active;
  assign done_out       = done;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // RQ4 RQ5 decrement and write-back
  dec_value_a: assert property (file_we_out |-> file_wdata_out == $past(file_rdata_in, 2) - 8'h01) // RQ4
    else $error("decrement result wrong");
  dest_file_a: assert property (file_we_out |-> dest_hold && op == bcd_dec_pkg::OP_DECR) // RQ5
    else $error("file write without destination");
  dest_acc_a: assert property ((write_phase && op == bcd_dec_pkg::OP_DECR && !dest_hold)
      |=> acc_out == $past(result) && !file_we_out) // RQ5
    else $error("accumulator not written");
  // RQ6 RQ7 RQ8 address mapping
  access_bank_a: assert property ((!active && start_in && !access_in && !ext_set_in)
      |=> file_addr_out[7:0] == $past(addr_in)
          && file_addr_out[11:8] == ($past(addr_in) < 8'h60 ? 4'h0 : 4'hF)) // RQ6
    else $error("access bank address wrong");
  banked_a: assert property ((!active && start_in && access_in)
      |=> file_addr_out == {$past(bank_select_register_in), $past(addr_in)}) // RQ7
    else $error("banked address wrong");
  indexed_a: assert property ((!active && start_in && !access_in && ext_set_in && addr_in <= 8'h5F)
      |=> file_addr_out == $past(index_base_in) + {4'h0, $past(addr_in)}) // RQ8
    else $error("indexed address wrong");
  // RQ1 RQ2 RQ3 digit correction
  adjust_digits_a: assert property ((write_phase && op == bcd_dec_pkg::OP_ADJUST)
      |=> acc_out[3:0] <= 4'h9 && acc_out[7:4] <= 4'h9) // RQ2
    else $error("adjust left non bcd digit");
  adjust_fix_a: assert property ((active && phase == bcd_dec_pkg::PH_Q3 && op == bcd_dec_pkg::OP_ADJUST
      && acc[3:0] > 4'h9) |=> result[3:0] == acc[3:0] - 4'hA) // RQ1
    else $error("low digit not corrected");
  adjust_carry_a: assert property ((active && phase == bcd_dec_pkg::PH_Q3 && op == bcd_dec_pkg::OP_ADJUST
      && acc[7:4] > 4'h9) |=> result_carry) // RQ3
    else $error("carry not set");
  // RQ4 four phases, done registered one edge after the write
  cycle_len_a: assert property ((!active && start_in) |-> ##5 done_out) // RQ4
    else $error("instruction not four phases");
  // RQ4 decrement leaves carry alone; other flags are out of scope here
  dec_carry_a: assert property ((write_phase && op == bcd_dec_pkg::OP_DECR)
      |=> carry_out == $past(carry)) // RQ4
    else $error("decrement changed carry");
  // RQ5 file write strobe lasts one phase only
  we_pulse_a: assert property (file_we_out |=> !file_we_out) // RQ5
    else $error("file write held too long");
  // RQ1 adjust works on the accumulator, never on the file
  adjust_file_a: assert property ((active && op == bcd_dec_pkg::OP_ADJUST)
      |-> !file_we_out) // RQ1
    else $error("adjust wrote the file");

  // covers: one per main scenario
  adjust_c: cover property (write_phase && op == bcd_dec_pkg::OP_ADJUST);
  dec_file_c: cover property (file_we_out);
  dec_acc_c: cover property (acc_write && op == bcd_dec_pkg::OP_DECR);
  indexed_c: cover property (!active && start_in && !access_in && ext_set_in && addr_in <= 8'h5F);
  banked_c: cover property (!active && start_in && access_in);
endmodule // bcd_dec_core

// File: rtl/decimal_fix.sv
// Purpose: combinational packed-bcd correction of one byte
// Assumes: input follows binary add of two packed bcd bytes
// Notes:   carry kept when no high-digit correction applies
module decimal_fix (
  // operand and flags
  input  wire logic [7:0] value_in,
  input  wire logic       carry_in,
  input  wire logic       half_in,
  // corrected result
  output logic      [7:0] value_out,
  output logic            carry_out
);
  wire       fix_lo = (value_in[3:0] > bcd_dec_pkg::DIGIT_MAX) | half_in;
  wire [4:0] lo_sum = {1'b0, value_in[3:0]} + (fix_lo ? {1'b0, bcd_dec_pkg::DIGIT_FIX} : 5'h00);
  // low-digit overflow ripples into high digit, as a true add would
  wire [4:0] hi_raw = {1'b0, value_in[7:4]} + {4'h0, lo_sum[4]};
  wire       fix_hi = (hi_raw > {1'b0, bcd_dec_pkg::DIGIT_MAX}) | carry_in;
  wire [4:0] hi_sum = hi_raw + (fix_hi ? {1'b0, bcd_dec_pkg::DIGIT_FIX} : 5'h00);
  // RQ3: per-digit correction
  assign value_out = {hi_sum[3:0], lo_sum[3:0]};
  assign carry_out = fix_hi | hi_sum[4] | carry_in;
endmodule // decimal_fix

// File: verif/bcd_adjust_and_decrement_ops_bench.sv
// Purpose: self-checking bench for the decimal adjust / decrement core
// Assumes: one op at a time, fields held stable from start until done
// Notes:   accumulator is loaded through a decrement with destination 0
module bcd_adjust_and_decrement_ops_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_in, start_in, adjust_sel_in, dest_in, access_in, ext_set_in;
  logic        carry_in, nibble_half_flag_in, file_we_out, carry_out, busy_out, done_out;
  logic [7:0]  addr_in, file_rdata_in, file_wdata_out, acc_out, wd_seen;
  logic [3:0]  bank_select_register_in;
  logic [11:0] index_base_in, file_addr_out;
  logic [31:0] seed;
  int          err_count, checks_done, we_seen, n;
  //////////////////////////////////////////////////////////////////////////////
  bcd_dec_core dut (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
    .adjust_sel_in(adjust_sel_in), .dest_in(dest_in), .access_in(access_in),
    .addr_in(addr_in), .ext_set_in(ext_set_in), .bank_select_register_in(bank_select_register_in),
    .index_base_in(index_base_in), .carry_in(carry_in), .nibble_half_flag_in(nibble_half_flag_in),
    .file_rdata_in(file_rdata_in), .file_addr_out(file_addr_out), .file_wdata_out(file_wdata_out),
    .file_we_out(file_we_out), .acc_out(acc_out), .carry_out(carry_out),
    .busy_out(busy_out), .done_out(done_out));
  // 100 ns period clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // pseudo-random source, fixed start so runs repeat
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // one instruction: fields stay put until done, so any sampling phase sees them
  task automatic run_op(input logic adj, d, a, x, input logic [7:0] f, r,
                        input logic [3:0] b, input logic [11:0] base, input logic cy, hf);
    @(posedge clk_in);
    start_in <= 1'b1;
    adjust_sel_in <= adj;
    dest_in <= d;
    access_in <= a;
    ext_set_in <= x;
    addr_in <= f;
    file_rdata_in <= r;
    bank_select_register_in <= b;
    index_base_in <= base;
    carry_in <= cy;
    nibble_half_flag_in <= hf;
    @(posedge clk_in);
    start_in <= 1'b0;
    #1;
    check("busy", busy_out, 1'b1);
    we_seen = 0;
    n = 0;
    while (n < 10 && done_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
      if (file_we_out === 1'b1) begin
        we_seen++;
        wd_seen = file_wdata_out;
      end
    end
    check("done latency", n, 4);
    check("idle at done", busy_out, 1'b0);
  endtask
  // load w by decrementing w+1 into the accumulator, then adjust it
  task automatic do_adjust(input logic [7:0] w, input logic cy, hf, input logic [7:0] ew,
                           input logic ec);
    run_op(1'b0, 1'b0, 1'b1, 1'b0, 8'h10, w + 8'h01, 4'h2, 12'h000, cy, hf);
    check("acc load", acc_out, w);
    run_op(1'b1, 1'b1, 1'b1, 1'b0, 8'h10, 8'h00, 4'h2, 12'h000, cy, hf);
    check("adjust acc", acc_out, ew);
    check("adjust carry", carry_out, ec);
    check("adjust no write", we_seen, 0);
  endtask
  // decrement with the address mapping worked out from the bank rules
  task automatic do_decr(input logic d, a, x, input logic [7:0] f, r, input logic [3:0] b,
                         input logic [11:0] base, input logic cy);
    logic [11:0] ea;
    logic [7:0]  old;
    old = acc_out;
    if (a) ea = {b, f};
    else if (x && f <= bcd_dec_pkg::INDEX_LIMIT) ea = base + {4'h0, f};
    else ea = (f < bcd_dec_pkg::ACCESS_SPLIT) ? {4'h0, f} : {bcd_dec_pkg::ACCESS_HI_BNK, f};
    run_op(1'b0, d, a, x, f, r, b, base, cy, 1'b0);
    check("file addr", file_addr_out, ea);
    check("write count", we_seen, d ? 1 : 0);
    if (d) check("write data", wd_seen, 8'(r - 8'h01));
    check("acc", acc_out, d ? old : 8'(r - 8'h01));
    check("carry kept", carry_out, cy);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int a, b, s, ds;
    {start_in, adjust_sel_in, dest_in, access_in, ext_set_in, carry_in} = '0;
    {nibble_half_flag_in, addr_in, file_rdata_in, bank_select_register_in, index_base_in} = '0;
    err_count = 0;
    checks_done = 0;
    seed = 32'h4E06;
    rst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    do_adjust(8'hA5, 1'b0, 1'b0, 8'h05, 1'b1);
    do_adjust(8'hCE, 1'b0, 1'b0, 8'h34, 1'b1);
    $display("adjust examples done");
    // random packed bcd sums against a decimal model
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      a = (seed[3:0] % 10) * 16 + seed[7:4] % 10;
      b = (seed[11:8] % 10) * 16 + seed[15:12] % 10;
      s = a + b;
      ds = (a / 16 * 10 + a % 16) + (b / 16 * 10 + b % 16);
      do_adjust(s[7:0], s > 255, (a % 16 + b % 16) > 15, ((ds % 100) / 10 * 16 + ds % 10),
                ds > 99);
    end
    $display("bcd sums done");
    // boundary of the indexed window, and wrap of zero
    do_decr(1'b1, 1'b0, 1'b1, 8'h5F, 8'h00, 4'h3, 12'h7F0, 1'b1);
    do_decr(1'b0, 1'b0, 1'b1, 8'h60, 8'h01, 4'h3, 12'h7F0, 1'b0);
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      do_decr(seed[0], seed[1], seed[2], seed[15:8], seed[23:16], seed[27:24],
              {seed[31:28], seed[7:0]}, seed[3]);
    end
    $display("decrements done");
    give_verdict();
  end
  // hang guard, roughly thirty times the expected run
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end
endmodule // bcd_adjust_and_decrement_ops_bench
